// ---- verilog/asc_pkg.sv ----
// Shared constants and types for both ends of the serial command link.
package asc_pkg;
	// ==========================================================
	// Timing
	localparam int SYS_PERIOD_NS = 4;
	localparam int MCLK_PERIOD_NS = 488;
	localparam int DECODE_MCLKS = 4;
	localparam int UPDATE_MCLKS = 4;
	localparam int DECODE_CYC = (DECODE_MCLKS * MCLK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int UPDATE_CYC = (UPDATE_MCLKS * MCLK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [9:0] DECODE_CNT = 10'(DECODE_CYC);
	localparam logic [9:0] UPDATE_CNT = 10'(UPDATE_CYC);
	localparam logic [2:0] SCLK_FALL_PH = 3'h4;
	localparam logic [2:0] SCLK_PRE_PH = 3'h7;

	// ==========================================================
	// Opcodes and frame layout
	localparam logic [7:0] OP_START = 8'h08;
	localparam logic [7:0] OP_STOP = 8'h0a;
	localparam logic [7:0] OP_CONT_ON = 8'h10;
	localparam logic [7:0] OP_CONT_OFF = 8'h11;
	localparam logic [7:0] OP_SINGLE = 8'h12;
	localparam logic [2:0] OP_REG_RD_HI = 3'h1;
	localparam logic [2:0] OP_REG_WR_HI = 3'h2;
	localparam logic [2:0] OP_COUNT_HI = 3'h0;
	localparam int FRAME_BITS = 216;
	localparam logic [5:0] FRAME_BYTES = 6'h1b;
	localparam int REG_COUNT = 32;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [4:0] ID_ADDR = 5'h00;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		CMD_START, CMD_STOP, CMD_CONT_ON, CMD_CONT_OFF,
		CMD_SINGLE, CMD_REG_RD, CMD_REG_WR, CMD_FETCH
	} asc_cmd_type;
	typedef enum logic [1:0] {
		DEV_OP1 = 2'b00, DEV_OP2 = 2'b01, DEV_DATA = 2'b11, DEV_SKIP = 2'b10
	} asc_dev_state_type;
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b000, HOST_WAIT = 3'b001, HOST_GAP = 3'b011,
		HOST_SHIFT = 3'b010, HOST_END = 3'b110
	} asc_host_state_type;
	typedef enum logic [1:0] {
		KIND_NONE, KIND_SAMPLE, KIND_REG_RD, KIND_REG_WR
	} asc_kind_type;
endpackage

// ---- verilog/asc_link_if.sv ----
// Serial link between the command host and the converter device.
`timescale 1ns/1ps
interface asc_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic sample_ready_n;
	logic start_pin;
	modport device (
		input sclk, cs_n, din, start_pin,
		output dout, dout_oe, sample_ready_n
	);
	modport host (
		output sclk, cs_n, din, start_pin,
		input dout, dout_oe, sample_ready_n
	);
endinterface

// ---- verilog/asc_device.sv ----
// Device end of the serial command link: decoder, registers and data output.
// ==========================================================
`timescale 1ns/1ps
module asc_device #(
	parameter logic [7:0] ID_VALUE = 8'h5a
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	asc_link_if.device link,
	input wire logic [asc_pkg::FRAME_BITS-1:0] frame_in,
	input wire logic frame_valid_in,
	output logic conv_run_out,
	output logic cont_mode_out
);
	import asc_pkg::*;

	// ==========================================================
	// Serial edge detection
	logic sclk_q;
	logic sel;
	logic rise;
	logic fall;
	logic seventh;
	logic eighth;
	logic [2:0] bit_cnt;
	logic [6:0] rx_sh;
	logic [6:0] rx_head;
	logic [7:0] rx_byte;
	asc_dev_state_type state;
	asc_kind_type kind;
	logic [4:0] addr;
	logic [4:0] remain;
	logic [7:0] regs [REG_COUNT];
	logic [7:0] tx_byte;
	logic [7:0] rd_val;
	logic [FRAME_BITS-1:0] result;
	logic [FRAME_BITS-1:0] rd_shift;
	logic shifted;
	logic run_cmd;
	logic [9:0] upd_cnt;
	logic sample_sh;
	logic single_hit;
	logic reg_out;

	assign sel = ~link.cs_n;
	assign rise = sel & link.sclk & ~sclk_q;
	assign fall = sel & ~link.sclk & sclk_q;
	assign seventh = fall && (bit_cnt == 3'h6);
	assign eighth = fall && (bit_cnt == 3'h7);
	assign rx_head = {rx_sh[5:0], link.din};
	assign rx_byte = {rx_sh, link.din};
	// The START, STOP and SINGLE prefixes are unique in their top seven bits among system opcodes.
	assign single_hit = seventh && (state == DEV_OP1) && (rx_head == OP_SINGLE[7:1]);
	assign reg_out = (state == DEV_DATA) && (kind == KIND_REG_RD);
	assign sample_sh = rise && (cont_mode_out || ((state == DEV_DATA) && (kind == KIND_SAMPLE)));
	assign rd_val = (addr == ID_ADDR) ? ID_VALUE : regs[addr];

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= link.sclk;
		end
	end

	// ==========================================================
	// Bit counter and receive shifter
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_cnt <= 3'h0;
			rx_sh <= 7'h00;
		end else if (!sel) begin
			bit_cnt <= 3'h0;
		end else if (fall) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh <= rx_head;
		end
	end

	// ==========================================================
	// Command sequencing
	// Dropping select always returns the decoder to the first opcode byte.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= DEV_OP1;
			kind <= KIND_NONE;
			addr <= 5'h00;
			remain <= 5'h00;
		end else if (!sel) begin
			state <= DEV_OP1;
			kind <= KIND_NONE;
		end else if (single_hit) begin
			kind <= KIND_SAMPLE;
		end else if (eighth) begin
			case (state)
				DEV_OP1: begin
					if (kind == KIND_SAMPLE) begin
						state <= DEV_DATA;
					end else if (rx_byte[7:5] == OP_REG_RD_HI) begin
						addr <= rx_byte[4:0];
						kind <= KIND_REG_RD;
						state <= cont_mode_out ? DEV_SKIP : DEV_OP2;
					end else if (rx_byte[7:5] == OP_REG_WR_HI) begin
						addr <= rx_byte[4:0];
						kind <= KIND_REG_WR;
						state <= DEV_OP2;
					end
				end
				DEV_OP2: begin
					remain <= rx_byte[4:0];
					state <= DEV_DATA;
				end
				DEV_DATA: begin
					if (kind != KIND_SAMPLE) begin
						addr <= addr + 5'h01;
						remain <= remain - 5'h01;
						if (remain == 5'h00) begin
							state <= DEV_SKIP;
						end
					end
				end
				default: begin
					state <= DEV_SKIP;
				end
			endcase
		end
	end

	// ==========================================================
	// Register file
	// The identity location is read-only, so writes to it are dropped.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= REG_RESET;
			end
		end else if (eighth && (state == DEV_DATA) && (kind == KIND_REG_WR)) begin
			if (addr != ID_ADDR) begin
				regs[addr] <= rx_byte;
			end
		end
	end

	// ==========================================================
	// Conversion and mode control
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_cmd <= 1'b0;
		end else if (seventh && (state == DEV_OP1)) begin
			if (rx_head == OP_START[7:1]) begin
				run_cmd <= 1'b1;
			end else if (rx_head == OP_STOP[7:1]) begin
				run_cmd <= 1'b0;
			end
		end
	end

	// The datapath finishes the conversion it holds, so only new starts are gated.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conv_run_out <= 1'b0;
		end else begin
			conv_run_out <= run_cmd | link.start_pin;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cont_mode_out <= 1'b1;
		end else if (eighth && (state == DEV_OP1)) begin
			if (rx_byte == OP_CONT_ON) begin
				cont_mode_out <= 1'b1;
			end else if (rx_byte == OP_CONT_OFF) begin
				cont_mode_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Result capture and data-ready strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result <= '0;
			upd_cnt <= 10'h000;
			link.sample_ready_n <= 1'b1;
		end else if (frame_valid_in) begin
			result <= frame_in;
			upd_cnt <= UPDATE_CNT;
			link.sample_ready_n <= 1'b1;
		end else if (upd_cnt != 10'h000) begin
			upd_cnt <= upd_cnt - 10'h001;
			if (upd_cnt == 10'h001) begin
				link.sample_ready_n <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Sample output shifter
	// A running single read owns the shifter, so a new result cannot corrupt it.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_shift <= '0;
		end else if (frame_valid_in && cont_mode_out && !(sel && shifted)) begin
			rd_shift <= frame_in;
		end else if (single_hit) begin
			rd_shift <= result;
		end else if (sample_sh) begin
			rd_shift <= {rd_shift[FRAME_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shifted <= 1'b0;
		end else if (!sel) begin
			shifted <= 1'b0;
		end else if (sample_sh) begin
			shifted <= 1'b1;
		end
	end

	// ==========================================================
	// Serial data output
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_byte <= 8'h00;
		end else if (rise && reg_out) begin
			tx_byte <= (bit_cnt == 3'h0) ? {rd_val[6:0], 1'b0} : {tx_byte[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.dout <= 1'b0;
		end else if (rise && reg_out) begin
			link.dout <= (bit_cnt == 3'h0) ? rd_val[7] : tx_byte[7];
		end else if (sample_sh) begin
			link.dout <= rd_shift[FRAME_BITS-1];
		end else if (rise) begin
			link.dout <= 1'b0;
		end else if (cont_mode_out && !shifted) begin
			link.dout <= link.sample_ready_n;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.dout_oe <= 1'b0;
		end else begin
			link.dout_oe <= sel;
		end
	end
endmodule

// ---- verilog/asc_host.sv ----
// Host end of the serial command link with its receive FIFO.
`timescale 1ns/1ps
module asc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	assign in_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid_out = (wr_ptr != rd_ptr);
	assign out_data_out = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_sys_in) begin
		if (in_valid_in && in_ready_out) begin
			mem[wr_ptr[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_in && in_ready_out) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid_out && out_ready_in) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module asc_host (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	asc_link_if.host link,
	input wire logic cmd_valid_in,
	input wire asc_pkg::asc_cmd_type cmd_op_in,
	input wire logic [4:0] cmd_addr_in,
	input wire logic [4:0] cmd_count_in,
	output logic cmd_ready_out,
	output logic cmd_refused_out,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in
);
	import asc_pkg::*;

	// ==========================================================
	// Transaction shape
	function automatic logic [7:0] op_byte(asc_cmd_type op, logic [5:0] i, logic [4:0] a,
			logic [4:0] c);
		case (op)
			CMD_START: op_byte = OP_START;
			CMD_STOP: op_byte = OP_STOP;
			CMD_CONT_ON: op_byte = OP_CONT_ON;
			CMD_CONT_OFF: op_byte = OP_CONT_OFF;
			CMD_SINGLE: op_byte = (i == 6'h00) ? OP_SINGLE : 8'h00;
			CMD_REG_RD: op_byte = (i == 6'h00) ? {OP_REG_RD_HI, a} :
				(i == 6'h01) ? {OP_COUNT_HI, c} : 8'h00;
			CMD_REG_WR: op_byte = (i == 6'h00) ? {OP_REG_WR_HI, a} :
				(i == 6'h01) ? {OP_COUNT_HI, c} : 8'h00;
			default: op_byte = 8'h00;
		endcase
	endfunction

	function automatic logic [5:0] op_len(asc_cmd_type op, logic [4:0] c);
		case (op)
			CMD_SINGLE: op_len = FRAME_BYTES + 6'h01;
			CMD_REG_RD, CMD_REG_WR: op_len = {1'b0, c} + 6'h03;
			CMD_FETCH: op_len = FRAME_BYTES;
			default: op_len = 6'h01;
		endcase
	endfunction

	asc_host_state_type state;
	asc_cmd_type op;
	logic [4:0] addr;
	logic [4:0] cnt;
	logic [5:0] bidx;
	logic [5:0] nbytes;
	logic [2:0] ph;
	logic [2:0] bits;
	logic [7:0] txb;
	logic [6:0] rxb;
	logic [9:0] gap;
	logic [9:0] since;
	logic cont;
	logic sample_ready_n_q;
	logic rx_push;
	logic [7:0] rx_data;
	logic fifo_ready;
	logic is_rx;
	logic is_wr;
	logic go;
	logic allowed;

	assign is_rx = ((op == CMD_SINGLE) && (bidx != 6'h00)) ||
		((op == CMD_REG_RD) && (bidx > 6'h01)) || (op == CMD_FETCH);
	assign is_wr = (op == CMD_REG_WR) && (bidx > 6'h01);
	// Reception waits for FIFO room, so a stalled reader throttles the link.
	assign go = (gap == 10'h000) && (!is_rx || fifo_ready);
	assign allowed = !cont || (cmd_op_in == CMD_CONT_OFF) || (cmd_op_in == CMD_FETCH);

	// ==========================================================
	// Data-ready tracking
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_ready_n_q <= 1'b1;
			since <= 10'h000;
		end else begin
			sample_ready_n_q <= link.sample_ready_n;
			if (sample_ready_n_q != link.sample_ready_n) begin
				since <= 10'h000;
			end else if (since < DECODE_CNT) begin
				since <= since + 10'h001;
			end
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= HOST_IDLE;
			op <= CMD_START;
			addr <= 5'h00;
			cnt <= 5'h00;
			bidx <= 6'h00;
			nbytes <= 6'h01;
			ph <= 3'h0;
			bits <= 3'h0;
			txb <= 8'h00;
			rxb <= 7'h00;
			gap <= 10'h000;
			cont <= 1'b1;
			rx_push <= 1'b0;
			rx_data <= 8'h00;
			cmd_ready_out <= 1'b1;
			cmd_refused_out <= 1'b0;
			wr_ready_out <= 1'b0;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.din <= 1'b0;
			link.start_pin <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			cmd_refused_out <= 1'b0;
			case (state)
				HOST_IDLE: begin
					if (cmd_valid_in && cmd_ready_out) begin
						cmd_refused_out <= !allowed;
						cmd_ready_out <= !allowed;
						op <= cmd_op_in;
						addr <= cmd_addr_in;
						cnt <= cmd_count_in;
						nbytes <= op_len(cmd_op_in, cmd_count_in);
						bidx <= 6'h00;
						gap <= 10'h000;
						state <= allowed ? HOST_WAIT : HOST_IDLE;
					end
				end
				HOST_WAIT: begin
					if (((op == CMD_SINGLE) || (op == CMD_FETCH)) && link.sample_ready_n) begin
						state <= HOST_WAIT;
					end else if ((op == CMD_CONT_ON) &&
							(link.sample_ready_n || (since < DECODE_CNT))) begin
						state <= HOST_WAIT;
					end else begin
						link.cs_n <= 1'b0;
						state <= HOST_GAP;
					end
				end
				HOST_GAP: begin
					if (gap != 10'h000) begin
						gap <= gap - 10'h001;
					end else if (is_wr) begin
						wr_ready_out <= !(wr_ready_out && wr_valid_in);
						if (wr_ready_out && wr_valid_in) begin
							txb <= wr_data_in;
							ph <= SCLK_PRE_PH;
							bits <= 3'h0;
							state <= HOST_SHIFT;
						end
					end else if (go) begin
						txb <= op_byte(op, bidx, addr, cnt);
						ph <= SCLK_PRE_PH;
						bits <= 3'h0;
						state <= HOST_SHIFT;
					end
				end
				HOST_SHIFT: begin
					ph <= ph + 3'h1;
					if (ph == 3'h0) begin
						link.sclk <= 1'b1;
						link.din <= txb[7];
						txb <= {txb[6:0], 1'b0};
					end else if (ph == SCLK_FALL_PH) begin
						link.sclk <= 1'b0;
						rxb <= {rxb[5:0], link.dout};
						bits <= bits + 3'h1;
						if (bits == 3'h7) begin
							rx_push <= is_rx;
							rx_data <= {rxb, link.dout};
							gap <= DECODE_CNT;
							if ((bidx == 6'h00) && (op == CMD_CONT_ON)) begin
								cont <= 1'b1;
							end
							if ((bidx == 6'h00) && (op == CMD_CONT_OFF)) begin
								cont <= 1'b0;
							end
							if (bidx == nbytes - 6'h01) begin
								state <= HOST_END;
							end else begin
								bidx <= bidx + 6'h01;
								state <= HOST_GAP;
							end
						end
					end
				end
				HOST_END: begin
					// Select rises a cycle after the last fall, so the device still decodes it.
					link.cs_n <= 1'b1;
					if (gap != 10'h000) begin
						gap <= gap - 10'h001;
					end else begin
						cmd_ready_out <= 1'b1;
						state <= HOST_IDLE;
					end
				end
				default: begin
					state <= HOST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Receive buffer
	asc_fifo #(
		.WIDTH(8),
		.DEPTH(16)
	) u_rx_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.in_data_in(rx_data),
		.in_valid_in(rx_push),
		.in_ready_out(fifo_ready),
		.out_data_out(rx_data_out),
		.out_valid_out(rx_valid_out),
		.out_ready_in(rx_ready_in)
	);
endmodule

// ---- verification/asc_link_chk.sv ----
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/1ps
module asc_link_chk (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic sample_ready_n,
	input wire logic start_pin
);
	import asc_pkg::*;
	logic sclk_q;
	logic [7:0] bits;
	logic [9:0] idle;
	logic [9:0] high;

	// ==========================================================
	// Helper counters
	// The high-time counter starts saturated, so a ready fall never preceded by a rise is skipped.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_q <= 1'b0;
			bits <= 8'h00;
			idle <= 10'h000;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				bits <= 8'h00;
			else if (sclk_q && !sclk)
				bits <= bits + 8'h01;
			if (sclk_q && !sclk)
				idle <= 10'h000;
			else if (idle != 10'h3ff)
				idle <= idle + 10'h001;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			high <= 10'h3ff;
		else if (!sample_ready_n)
			high <= 10'h000;
		else if (high != 10'h3ff)
			high <= high + 10'h001;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_next_byte;
		$rose(sclk) && bits[2:0] == 3'h0 && bits != 8'h00;
	endsequence
	property p_start_low; !start_pin; endproperty
	property p_sclk_idle; cs_n |-> !sclk; endproperty
	property p_sclk_high; $rose(sclk) |=> sclk[*3]; endproperty
	property p_sclk_low; $fell(sclk) |=> !sclk[*3]; endproperty
	property p_byte_gap; s_next_byte |-> idle >= DECODE_CNT - 10'h001; endproperty
	property p_oe_on; (!cs_n)[*4] |-> dout_oe; endproperty
	property p_oe_off; cs_n[*4] |-> !dout_oe; endproperty
	property p_ready_hold; $rose(sample_ready_n) |=> sample_ready_n[*8]; endproperty
	property p_ready_time;
		$fell(sample_ready_n) && high != 10'h3ff |->
			high >= UPDATE_CNT - 10'h002 && high <= UPDATE_CNT + 10'h002;
	endproperty
	property p_din_edge; $changed(din) && !cs_n |-> $rose(sclk); endproperty
	property p_dout_edge; $changed(dout) && !cs_n && !$past(cs_n, 4) |-> sclk; endproperty
	a_start_low: assert property (p_start_low) else $error("start pin high");
	a_sclk_idle: assert property (p_sclk_idle) else $error("clock while deselected");
	a_sclk_high: assert property (p_sclk_high) else $error("clock high too short");
	a_sclk_low: assert property (p_sclk_low) else $error("clock low too short");
	a_byte_gap: assert property (p_byte_gap) else $error("byte gap too short");
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	a_oe_off: assert property (p_oe_off) else $error("output driven unselected");
	a_ready_hold: assert property (p_ready_hold) else $error("ready pulse short");
	a_ready_time: assert property (p_ready_time) else $error("update time wrong");
	a_din_edge: assert property (p_din_edge) else $error("input off edge");
	a_dout_edge: assert property (p_dout_edge) else $error("output off edge");
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench joining the host and device ends of the serial link.
`timescale 1ns/1ps
module testbench;
	import asc_pkg::*;
	localparam logic [7:0] ID_TB = 8'h69; // Arbitrary identity value.
	localparam logic [FRAME_BITS-1:0] F1 = {9{24'h9c5a31}};
	localparam logic [FRAME_BITS-1:0] F2 = {9{24'h1e87f0}};
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [FRAME_BITS-1:0] frame = 216'h0;
	logic frame_valid = 1'b0;
	logic conv_run, cont_mode, cmd_ready, cmd_refused, wr_ready, rx_valid, refused;
	logic cmd_valid = 1'b0;
	asc_cmd_type cmd_op = CMD_START;
	logic [4:0] cmd_addr = 5'h00;
	logic [4:0] cmd_count = 5'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic [7:0] rx_data;
	logic rx_ready = 1'b0;
	int compares = 0;
	int mismatches = 0;

	asc_link_if link ();
	asc_device #(.ID_VALUE(ID_TB)) i_asc_device (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.link(link), .frame_in(frame), .frame_valid_in(frame_valid),
		.conv_run_out(conv_run), .cont_mode_out(cont_mode));
	asc_host i_asc_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(link),
		.cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
		.cmd_count_in(cmd_count), .cmd_ready_out(cmd_ready), .cmd_refused_out(cmd_refused),
		.wr_data_in(wr_data), .wr_valid_in(wr_valid), .wr_ready_out(wr_ready),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
	asc_link_chk i_asc_link_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sclk(link.sclk),
		.cs_n(link.cs_n), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
		.sample_ready_n(link.sample_ready_n), .start_pin(link.start_pin));

	always #2 clk_sys_in = !clk_sys_in;

	// ==========================================================
	// Shared tasks
	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 30000) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk_bit("command done", 1'b1, cmd_ready);
	endtask
	// The refusal pulse lasts one cycle, so both cycles after the take are looked at.
	task automatic issue(input asc_cmd_type op, input logic [4:0] addr, input logic [4:0] cnt,
		input logic exp_ref);
		@(negedge clk_sys_in);
		cmd_op = op;
		cmd_addr = addr;
		cmd_count = cnt;
		cmd_valid = 1'b1;
		@(negedge clk_sys_in);
		cmd_valid = 1'b0;
		refused = cmd_refused;
		@(negedge clk_sys_in);
		refused = refused | cmd_refused;
		chk_bit("command refused", exp_ref, refused);
	endtask
	task automatic send_byte(input logic [7:0] b);
		int n;
		n = 0;
		wr_data = b;
		wr_valid = 1'b1;
		while (wr_ready !== 1'b1 && n < 5000) begin
			@(negedge clk_sys_in);
			n++;
		end
		@(negedge clk_sys_in);
	endtask
	task automatic recv(input int cnt, input logic [FRAME_BITS-1:0] src, input int stall);
		int got;
		int n;
		got = 0;
		n = 0;
		repeat (stall) @(negedge clk_sys_in);
		if (stall > 0)
			chk_bit("stalled buffer holds data", 1'b1, rx_valid);
		rx_ready = 1'b1;
		while (got < cnt && n < 40000) begin
			if (rx_valid === 1'b1) begin
				chk_byte("received byte", src[FRAME_BITS-1-8*got -: 8], rx_data);
				got++;
			end
			@(negedge clk_sys_in);
			n++;
		end
		chk_bit("all bytes received", 1'b1, got == cnt);
		rx_ready = 1'b0;
	endtask
	task automatic push_frame(input logic [FRAME_BITS-1:0] f, input logic follow);
		int n;
		logic prev;
		n = 0;
		@(negedge clk_sys_in);
		frame = f;
		frame_valid = 1'b1;
		@(negedge clk_sys_in);
		frame_valid = 1'b0;
		prev = link.sample_ready_n;
		while (link.sample_ready_n !== 1'b0 && n < 2000) begin
			@(negedge clk_sys_in);
			if (follow)
				chk_bit("idle data output", prev, link.dout);
			prev = link.sample_ready_n;
			n++;
		end
		chk_bit("data ready low", 1'b0, link.sample_ready_n);
		if (follow) begin
			@(negedge clk_sys_in);
			chk_bit("idle data output", 1'b0, link.dout);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk_bit("continuous after reset", 1'b1, cont_mode);
		chk_bit("halted after reset", 1'b0, conv_run);
		issue(CMD_REG_RD, 5'h00, 5'h00, 1'b1);
		issue(CMD_REG_WR, 5'h01, 5'h00, 1'b1);
	endtask
	task automatic t_cont_read();
		push_frame(F1, 1'b1);
		issue(CMD_FETCH, 5'h00, 5'h00, 1'b0);
		recv(int'(FRAME_BYTES), F1, 12000);
		wait_idle();
		issue(CMD_CONT_OFF, 5'h00, 5'h00, 1'b0);
		wait_idle();
		chk_bit("continuous mode left", 1'b0, cont_mode);
	endtask
	task automatic t_run();
		asc_cmd_type ops [4] = '{CMD_START, CMD_START, CMD_STOP, CMD_STOP};
		logic [3:0] runs = 4'hc;
		for (int i = 0; i < 4; i++) begin
			issue(ops[i], 5'h00, 5'h00, 1'b0);
			wait_idle();
			chk_bit("conversions running", runs[3-i], conv_run);
		end
	endtask
	task automatic t_regs();
		issue(CMD_REG_WR, 5'h01, 5'h01, 1'b0);
		send_byte(8'ha5);
		send_byte(8'h3c);
		wr_valid = 1'b0;
		wait_idle();
		issue(CMD_REG_WR, 5'h00, 5'h00, 1'b0);
		send_byte(8'hff);
		wr_valid = 1'b0;
		wait_idle();
		issue(CMD_REG_RD, 5'h00, 5'h03, 1'b0);
		recv(4, {ID_TB, 8'ha5, 8'h3c, 8'h00, 184'h0}, 0);
		wait_idle();
	endtask
	task automatic t_single();
		issue(CMD_START, 5'h00, 5'h00, 1'b0);
		wait_idle();
		push_frame(F2, 1'b0);
		issue(CMD_SINGLE, 5'h00, 5'h00, 1'b0);
		recv(int'(FRAME_BYTES), F2, 0);
		wait_idle();
		issue(CMD_CONT_ON, 5'h00, 5'h00, 1'b0);
		wait_idle();
		chk_bit("continuous mode entered", 1'b1, cont_mode);
		issue(CMD_REG_RD, 5'h00, 5'h00, 1'b1);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		rst_n_in = 1'b1;
		@(negedge clk_sys_in);
		t_reset();
		t_cont_read();
		t_run();
		t_regs();
		t_single();
		stop_test();
	end
	// The whole sequence needs about 46000 cycles; the limit leaves margin below the run cap.
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		mismatches++;
		$display("Error watchdog expected finish seen hang");
		stop_test();
	end
endmodule
